/* File: design/css_pkg.sv */
// package: constants, types and register map of the card session sequencer
package css_pkg;
    // register byte offsets (our own map)
    localparam logic [7:0] CSS_PWR_OFS = 8'h00;
    localparam logic [7:0] CSS_STAT_OFS = 8'h04;
    localparam logic [7:0] CSS_UCTL2_OFS = 8'h08;
    localparam logic [7:0] CSS_FLT_OFS = 8'h0C;
    // power control register fields
    localparam int CSS_PWR_START = 0;
    localparam int CSS_PWR_RST = 2;
    localparam int CSS_PWR_C4 = 4;
    localparam int CSS_PWR_C8 = 5;
    localparam logic [7:0] CSS_PWR_RESET = 8'h30;
    // hardware status register fields
    localparam int CSS_STAT_HOT = 0;
    localparam int CSS_STAT_CHG = 2;
    localparam int CSS_STAT_CARD = 3;
    localparam int CSS_STAT_SLOW = 4;
    localparam int CSS_STAT_PROT = 5;
    // second uart control: wake enable bit
    localparam int CSS_UCTL2_ENWAKE = 7;
    // timing: sequencer tick is fint/64; a step is one half-t (32 ticks of the base clock div)
    localparam int CSS_CLK_MHZ = 200;
    localparam int CSS_TICK_DIV = 64;
    localparam int CSS_T_US = 25;
    // half-t in ns and clock cycles; one sequencer tick is t/64 of the 25 us t
    localparam int CSS_HALF_T_NS = CSS_T_US * 1000 / 2;
    localparam int CSS_HALF_T_CYC = CSS_HALF_T_NS * CSS_CLK_MHZ / 1000;
    localparam int CSS_T64_CYC = CSS_HALF_T_CYC * 2 / CSS_TICK_DIV;
    // activation steps in half-t from converter start
    localparam logic [3:0] CSS_ACT_VCC = 4'h5;
    localparam logic [3:0] CSS_ACT_IO = 4'h9;
    localparam logic [3:0] CSS_ACT_CLK = 4'hA;
    // deactivation steps in half-t after reset falls
    localparam logic [3:0] CSS_DEA_CLK = 4'h1;
    localparam logic [3:0] CSS_DEA_IO = 4'h2;
    localparam logic [3:0] CSS_DEA_VCC = 4'h3;
    localparam logic [3:0] CSS_DEA_OFF = 4'h7;
    // alarm stretch: 1 ms per 2 nF, capacitor in nF
    localparam int CSS_ALARM_US_PER_2NF = 1000;
    localparam int CSS_WAKE_HOLD_CYC = 64;

    typedef enum logic [2:0]
    {
        CSS_IDLE = 3'b000,
        CSS_ACT = 3'b001,
        CSS_ON = 3'b010,
        CSS_DLY = 3'b011,
        CSS_DEA = 3'b100
    } css_state_e;

    // card contact drive bundle
    typedef struct packed
    {
        logic dcdc_on;
        logic vcc_on;
        logic io_on;
        logic clk_on;
        logic rst;
        logic c4;
        logic c8;
        logic hiz_n;
    } css_contacts_s;
endpackage

/* File: design/css_sync.sv */
// module: two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module css_sync #(
    parameter int W = 4
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* File: design/css_top.sv */
// module: card session sequencer with supervisor, status and axi4-lite registers
//
// Summary of operation
// RQ1: supply below working level emits an alarm pulse, length set by capacitor.
// RQ2: alarm acts as power-on reset, blanks contacts, forces deactivation on drop.
// RQ3: supply-low flag set after alarm; cleared by status read outside alarm.
// RQ4: card event interrupt held low while power-on reset is active.
// RQ5: reset pin held high at least 100 us; treated like an alarm.
// RQ6: start bit activates only with card present and no alarm.
// RQ7: status shows presence; presence-change flag latches on every toggle.
// RQ8: faults deactivate an active session; status update drives interrupt low.
// RQ9: removal, overcurrents, overtemperature, supply low, reset pin trigger deactivation.
// RQ10: trip at 100 mA supply, 20 mA reset line, 150 C die.
// RQ11: inactive card keeps all contacts low, converter stopped.
// RQ12: software sets up uart before start, only with no error flag.
// RQ13: activation order: converter, supply, data/aux, then clock and reset.
// RQ14: tick fint/64, t 25 us; supply 2.5t, contacts 4.5t, clock 5t.
// RQ15: after counted clocks software sets reset request; device raises reset line.
// RQ16: start cleared: reset t/64, clock t/2, io t, vcc 1.5t, off 3.5t.
// RQ17: removal, overcurrent, overheat: interrupt low, flag set, start cleared.
// RQ18: supply drop: deactivate, full reset, supply-low flag after recovery.
// RQ19: controller reset by reset pin or supervisor power-on reset.
// RQ20: card interrupt shared by uart, drivers and counters; second one for usb.
// RQ21: falling edge on either interrupt wakes controller; delay counter, enable bit.
// RQ22: while active the reset line copies the reset request bit.
// RQ23: interrupt service reads status registers to find and clear the cause.
// RQ24: start while not permitted leaves every contact inactive.
`timescale 1ns/1ps
module css_top
    import css_pkg::*;
#(
    parameter int ALARM_CAP_NF = 2, // delay capacitor value in nF
    parameter int ALARM_CYC = ALARM_CAP_NF * CSS_ALARM_US_PER_2NF * CSS_CLK_MHZ / 2
) (
    input wire logic aclk, // 200 MHz clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic vdd_low, // supervisor comparator, supply too low
    input wire logic reset_pin, // external reset pin, active high
    input wire logic card_present_input, // card presence switch
    input wire logic icc_over, // card supply at 100 mA limit
    input wire logic rst_over, // reset line at 20 mA limit
    input wire logic die_hot, // die above 150 C
    input wire logic usb_event, // usb interface wants service
    input wire logic event_req, // uart and etu counter event level
    output logic alarm_out, // supervisor alarm pulse
    output logic cpu_reset, // controller reset, active high
    output logic card_event_irq_n, // card event interrupt, active low
    output logic usb_irq_n, // usb interrupt, active low
    output css_contacts_s contacts // card contact drive
);
    // ---- pin synchronisers
    logic [6:0] pin_s;
    css_sync #(.W(7)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({usb_event, vdd_low, reset_pin, card_present_input, icc_over, rst_over, die_hot}),
        .q(pin_s)
    );
    wire usb_s = pin_s[6];
    wire vdd_low_s = pin_s[5];
    wire rpin_s = pin_s[4];
    wire card_s = pin_s[3];
    wire prot_s = pin_s[2] | pin_s[1]; // [RQ10]
    wire hot_s = pin_s[0]; // [RQ10]

    // ---- supervisor alarm stretch: restarts while supply is low
    logic [31:0] alarm_cnt_q;
    logic alarm_q;
    wire alarm_src = vdd_low_s | rpin_s; // [RQ5]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_cnt_q <= 32'(ALARM_CYC);
            alarm_q <= 1'b1;
        end
        else if (alarm_src)
        begin
            alarm_cnt_q <= 32'(ALARM_CYC); // [RQ1]
            alarm_q <= 1'b1;
        end
        else if (alarm_cnt_q != 32'h0)
            alarm_cnt_q <= alarm_cnt_q - 32'h1;
        else
            alarm_q <= 1'b0;
    end

    // ---- divider: one enable every 1/64 of t, and a half-t step
    localparam int T64W = $clog2(CSS_T64_CYC + 1);
    localparam int T64_MAX = CSS_T64_CYC;
    css_state_e st_q, st_d;
    logic [T64W-1:0] div_q;
    logic [4:0] sub_q;
    wire tick64 = (div_q == T64W'(CSS_T64_CYC - 1)); // [RQ14]
    wire half_t = tick64 && (sub_q == 5'h1F); // 32 sixty-fourths
    always_ff @(posedge aclk)
    begin
        // restart on every state change so each step lands a whole number of half-t in
        if (!aresetn || alarm_q || st_d != st_q)
        begin
            div_q <= '0;
            sub_q <= '0;
        end
        else
        begin
            div_q <= tick64 ? '0 : div_q + T64W'(1);
            if (tick64)
                sub_q <= sub_q + 5'h1;
        end
    end

    // ---- registers
    logic [7:0] pwr_q;
    logic [7:0] uctl2_q;
    logic sup_low_q, chg_q, prot_q, hot_q, card_q;
    logic [3:0] step_q;

    // axi write handshake: address and data taken in either order
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_pwr = do_wr && awaddr_q == CSS_PWR_OFS && wstrb_q[0];
    wire wr_uctl2 = do_wr && awaddr_q == CSS_UCTL2_OFS && wstrb_q[0];
    wire wr_ok = awaddr_q == CSS_PWR_OFS || awaddr_q == CSS_UCTL2_OFS;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = !aw_got_q && aresetn;
    assign s_axi_wready = !w_got_q && aresetn;

    // axi read: data registered one cycle after address
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] raddr = {s_axi_araddr[7:2], 2'h0};
    wire [7:0] stat_v = {2'b00, prot_q, sup_low_q, card_q, chg_q, 1'b0, hot_q};
    wire [7:0] pwr_v = {2'b00, contacts.c8, contacts.c4, pwr_q[3:0]};
    wire [7:0] flt_v = {5'h0, st_q};
    wire rd_stat = rd_take && raddr == CSS_STAT_OFS;
    // status reads outside the alarm clear the sticky flags
    wire stat_clr = rd_stat && !alarm_q; // [RQ3]
    logic [7:0] rmux;
    always_comb
    begin
        case (raddr)
            CSS_PWR_OFS: rmux = pwr_v;
            CSS_STAT_OFS: rmux = stat_v;
            CSS_UCTL2_OFS: rmux = uctl2_q;
            CSS_FLT_OFS: rmux = flt_v;
            default: rmux = 8'h00;
        endcase
    end
    wire rd_ok = raddr <= CSS_FLT_OFS;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rmux};
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid && aresetn;

    // ---- fault detection
    wire card_tgl = card_s != card_q; // [RQ7]
    wire card_fault = !card_s || prot_s || hot_s; // [RQ17]
    wire any_fault = card_fault || alarm_q || sup_low_q; // [RQ9]
    wire sess = st_q != CSS_IDLE;
    wire permit = card_s && !alarm_q; // [RQ6]

    // status flags: a hardware set wins over a read clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sup_low_q <= 1'b1;
            chg_q <= 1'b0;
            prot_q <= 1'b0;
            hot_q <= 1'b0;
            card_q <= 1'b0;
        end
        else
        begin
            card_q <= card_s;
            sup_low_q <= alarm_q | (sup_low_q & !stat_clr); // [RQ3] [RQ18]
            chg_q <= card_tgl | (chg_q & !stat_clr); // [RQ7]
            prot_q <= (prot_s & sess) | (prot_q & !stat_clr); // [RQ9]
            hot_q <= (hot_s & sess) | (hot_q & !stat_clr); // [RQ9]
        end
    end

    // power control and uart control registers; start auto-cleared on faults during a session
    always_ff @(posedge aclk)
    begin
        if (!aresetn || alarm_q)
        begin
            pwr_q <= CSS_PWR_RESET; // [RQ18] [RQ19]
            uctl2_q <= 8'h00;
        end
        else
        begin
            if (wr_pwr)
                pwr_q <= wdata_q[7:0];
            if (sess && card_fault)
                pwr_q[CSS_PWR_START] <= 1'b0; // [RQ17]
            if (wr_uctl2)
                uctl2_q <= wdata_q[7:0];
        end
    end

    // ---- sequencer
    wire start = pwr_q[CSS_PWR_START];
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            CSS_IDLE: if (start && permit && !any_fault) st_d = CSS_ACT; // [RQ6] [RQ24]
            CSS_ACT:
                if (!start || any_fault) st_d = CSS_DLY;
                else if (half_t && step_q == CSS_ACT_CLK - 4'h1) st_d = CSS_ON;
            CSS_ON: if (!start || any_fault) st_d = CSS_DLY; // [RQ8]
            CSS_DLY: if (tick64) st_d = CSS_DEA; // [RQ16]
            CSS_DEA: if (half_t && step_q == CSS_DEA_OFF - 4'h1) st_d = CSS_IDLE;
            default: st_d = CSS_IDLE;
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= CSS_IDLE;
            step_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (st_d != st_q)
                step_q <= '0;
            else if (half_t)
                step_q <= step_q + 4'h1;
        end
    end

    // contact drive, ordered by half-t steps
    css_contacts_s c_d;
    always_comb
    begin
        c_d = '0;
        case (st_q)
            CSS_ACT:
            begin
                c_d.dcdc_on = 1'b1; // [RQ13]
                c_d.hiz_n = 1'b1;
                c_d.vcc_on = step_q >= CSS_ACT_VCC; // [RQ14]
                c_d.io_on = step_q >= CSS_ACT_IO;
                c_d.c4 = c_d.io_on & pwr_q[CSS_PWR_C4];
                c_d.c8 = c_d.io_on & pwr_q[CSS_PWR_C8];
            end
            CSS_ON, CSS_DLY:
            begin
                c_d = '{1'b1, 1'b1, 1'b1, 1'b1, pwr_q[CSS_PWR_RST], pwr_q[CSS_PWR_C4],
                        pwr_q[CSS_PWR_C8], 1'b1}; // [RQ15] [RQ22]
            end
            CSS_DEA:
            begin
                c_d.dcdc_on = 1'b1;
                c_d.hiz_n = 1'b1;
                c_d.clk_on = step_q < CSS_DEA_CLK; // [RQ16]
                c_d.io_on = step_q < CSS_DEA_IO;
                c_d.vcc_on = step_q < CSS_DEA_VCC;
                c_d.c4 = c_d.io_on & pwr_q[CSS_PWR_C4];
                c_d.c8 = c_d.io_on & pwr_q[CSS_PWR_C8];
            end
            default: c_d = '0; // [RQ11] [RQ24]
        endcase
    end

    // ---- interrupts and wake hold: card event interrupt low on any status event or reset
    logic [6:0] wake_q;
    wire stat_evt = card_tgl || (sess && card_fault) || (alarm_q && !sup_low_q);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_q <= '0;
            contacts <= '0;
            card_event_irq_n <= 1'b0;
            usb_irq_n <= 1'b1;
            alarm_out <= 1'b1;
            cpu_reset <= 1'b1;
        end
        else
        begin
            if (stat_evt)
                wake_q <= 7'(CSS_WAKE_HOLD_CYC - 1); // [RQ21]
            else if (wake_q != 7'h0)
                wake_q <= wake_q - 7'h1;
            contacts <= alarm_q ? '0 : c_d; // [RQ2]
            // shared by drivers, uart and etu counters [RQ20]
            card_event_irq_n <= !(alarm_q || stat_evt || wake_q != 7'h0 || event_req
                                  || chg_q || prot_q || hot_q); // [RQ4] [RQ8] [RQ23]
            usb_irq_n <= !(usb_s && uctl2_q[CSS_UCTL2_ENWAKE]); // [RQ20] [RQ21]
            alarm_out <= alarm_q; // [RQ1]
            cpu_reset <= alarm_q; // [RQ19]
        end
    end

    // ---- checks
    a_irq_during_por: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_q |=> !card_event_irq_n) else $error("irq high during reset"); // [RQ4]
    a_idle_contacts: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == CSS_IDLE |=> contacts == '0) else $error("contacts live idle"); // [RQ11]
    a_no_act_absent: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == CSS_IDLE && !card_s |=> st_q == CSS_IDLE)
        else $error("activation without card"); // [RQ6]
    a_start_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        sess && card_fault && !alarm_q |=> !pwr_q[CSS_PWR_START])
        else $error("start not cleared"); // [RQ17]
    a_rst_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == CSS_ON && !alarm_q |=> contacts.rst == $past(pwr_q[CSS_PWR_RST]))
        else $error("reset line not copy"); // [RQ22]
    a_low_set: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_q |=> sup_low_q) else $error("supply low not set"); // [RQ3]
    a_chg_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        card_tgl |=> chg_q) else $error("presence change lost"); // [RQ7]
    a_dly_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == CSS_DLY |-> ##[1:T64_MAX] st_q == CSS_DEA)
        else $error("reset fall late"); // [RQ16]
    a_order_act: assert property (@(posedge aclk) disable iff (!aresetn)
        contacts.io_on |-> contacts.vcc_on && contacts.dcdc_on)
        else $error("contact order broken"); // [RQ13]
endmodule

/* File: dv/css_card_model.sv */
// smart card partner model facing the card contacts
`timescale 1ns/1ps
module css_card_model
    import css_pkg::*;
(
    input wire logic inserted, // card sits in the slot
    input wire logic short_on, // card contacts shorted
    input wire css_contacts_s contacts, // contact drive from the reader
    output logic card_present_input, // presence switch
    output logic icc_over, // supply current trip
    output logic rst_over // reset line current trip
);
    // a short only draws current once the reader powers that contact
    assign card_present_input = inserted;
    assign icc_over = short_on & contacts.vcc_on;
    assign rst_over = short_on & contacts.rst;
endmodule

/* File: dv/tb_css_top.sv */
// self-checking bench for the card session sequencer
`timescale 1ns/1ps
module tb_css_top
    import css_pkg::*;
;
    typedef struct {logic [31:0] exp; logic [31:0] msk; logic [1:0] rsp;} css_bus_note_s;
    typedef struct {logic [4:0] val; int dly; int tol;} css_pin_note_s;
    // half-t is 32 sequencer ticks of whole clock cycles
    localparam int H = CSS_T64_CYC * CSS_TICK_DIV / 2;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic vdd_low, reset_pin, present, icc_over, rst_over, die_hot, usb_event, event_req;
    logic alarm_out, cpu_reset, irq_n, usb_irq_n, inserted, short_on;
    logic [4:0] pins, last;
    css_contacts_s contacts;
    css_bus_note_s bq[$];
    css_bus_note_s bn;
    css_pin_note_s pq[$];
    css_pin_note_s pn;
    int err_count, compares, cyc, mark;

    css_top #(.ALARM_CAP_NF(2), .ALARM_CYC(50)) u_css_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .vdd_low(vdd_low), .reset_pin(reset_pin), .card_present_input(present),
        .icc_over(icc_over), .rst_over(rst_over), .die_hot(die_hot), .usb_event(usb_event),
        .event_req(event_req), .alarm_out(alarm_out), .cpu_reset(cpu_reset),
        .card_event_irq_n(irq_n), .usb_irq_n(usb_irq_n), .contacts(contacts));

    css_card_model u_css_card_model (.inserted(inserted), .short_on(short_on),
        .contacts(contacts), .card_present_input(present), .icc_over(icc_over),
        .rst_over(rst_over));

    // powered contact lines only; c4 and c8 follow their own bits, impedance mirrors dcdc_on
    assign pins = {contacts.dcdc_on, contacts.vcc_on, contacts.io_on, contacts.clk_on, contacts.rst};

    // 200 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // write one register; upper data bytes and strobes are random filler
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic [31:0] x;
        @(posedge aclk);
        x = xs();
        bq.push_back('{32'h0, 32'h0, r});
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {x[31:8], d};
        wstrb <= {x[3:1], 1'b1};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic [1:0] r);
        @(posedge aclk);
        bq.push_back('{e, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic wait_pins();
        while (pq.size() != 0)
            @(posedge aclk);
    endtask

    // activation then reset request; first step noted within 200 cycles of the start write
    task automatic up();
        mark = cyc;
        pq.push_back('{5'b10000, 100, 100});
        pq.push_back('{5'b11000, 5 * H, 2});
        pq.push_back('{5'b11100, 4 * H, 2});
        pq.push_back('{5'b11110, H, 2});
        axw(CSS_PWR_OFS, 8'h31, 2'b00);
        wait_pins();
        mark = cyc;
        pq.push_back('{5'b11111, 5, 5});
        axw(CSS_PWR_OFS, 8'h35, 2'b00);
        wait_pins();
    endtask

    task automatic down_notes();
        mark = cyc;
        pq.push_back('{5'b11110, 100, 100});
        pq.push_back('{5'b11100, H, 2});
        pq.push_back('{5'b11000, H, 2});
        pq.push_back('{5'b10000, H, 2});
        pq.push_back('{5'b00000, 4 * H, 2});
    endtask

    // score each bus answer against the oldest note
    always @(posedge aclk)
    begin
        if ((bvalid && bready) || (rvalid && rready))
        begin
            if (bq.size() == 0)
                chk("bus note", 32'h1, 32'h0);
            else
            begin
                bn = bq.pop_front();
                if (bvalid)
                    chk("bresp", bn.rsp, bresp);
                else
                begin
                    chk("rresp", bn.rsp, rresp);
                    chk("rdata", bn.exp, rdata & bn.msk);
                end
            end
        end
    end

    // every contact change must be the next noted step, at the noted gap
    always @(posedge aclk)
    begin
        cyc++;
        if (aresetn && pins !== last)
        begin
            if (pq.size() == 0)
                chk("contacts unexpected", last, pins);
            else
            begin
                pn = pq.pop_front();
                chk("contacts", pn.val, pins);
                chk("step gap", pn.dly, (cyc - mark >= pn.dly - pn.tol &&
                    cyc - mark <= pn.dly + pn.tol) ? pn.dly : cyc - mark);
            end
            mark = cyc;
        end
        last = pins;
    end

    // watchdog sized a little above the two sessions and the long reset pin
    initial
    begin
        repeat (130000) @(posedge aclk);
        err_count++;
        test_done();
    end

    initial
    begin
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {wdata, wstrb, vdd_low, reset_pin, die_hot, usb_event, event_req} = '0;
        {inserted, short_on, last, err_count, compares, cyc, mark} = '0;
        seed = 32'h31;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
        chk("alarm", 32'h1, alarm_out);
        chk("irq in reset", 32'h0, irq_n);
        while (alarm_out)
            @(posedge aclk);
        chk("cpu reset", 32'h0, cpu_reset);
        axr(CSS_STAT_OFS, 32'h10, 32'h18, 2'b00);
        axr(CSS_STAT_OFS, 32'h00, 32'h10, 2'b00);
        repeat (100) @(posedge aclk);
        chk("irq idle", 32'h1, irq_n);
        // start with no card: the watcher flags any contact movement
        axw(CSS_PWR_OFS, 8'h31, 2'b00);
        repeat (500) @(posedge aclk);
        axw(CSS_PWR_OFS, 8'h30, 2'b00);
        inserted <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("irq on insert", 32'h0, irq_n);
        axr(CSS_STAT_OFS, 32'h0C, 32'h0C, 2'b00);
        axr(CSS_STAT_OFS, 32'h08, 32'h0C, 2'b00);
        up();
        down_notes();
        axw(CSS_PWR_OFS, 8'h34, 2'b00);
        wait_pins();
        up();
        down_notes();
        // short and overheat together, so one session covers both flags
        short_on <= 1'b1;
        die_hot <= 1'b1;
        wait_pins();
        short_on <= 1'b0;
        die_hot <= 1'b0;
        chk("irq on fault", 32'h0, irq_n);
        axr(CSS_STAT_OFS, 32'h21, 32'h21, 2'b00);
        axr(CSS_PWR_OFS, 32'h00, 32'h01, 2'b00);
        // overheat outside a session leaves the flag clear
        die_hot <= 1'b1;
        repeat (10) @(posedge aclk);
        die_hot <= 1'b0;
        axr(CSS_STAT_OFS, 32'h00, 32'h01, 2'b00);
        axr(8'h10, 32'h0, 32'h0, 2'b10);
        axw(CSS_STAT_OFS, 8'h00, 2'b10);
        axw(CSS_UCTL2_OFS, 8'h80, 2'b00);
        usb_event <= 1'b1;
        event_req <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("usb irq", 32'h0, usb_irq_n);
        chk("irq shared", 32'h0, irq_n);
        usb_event <= 1'b0;
        event_req <= 1'b0;
        vdd_low <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("alarm on drop", 32'h1, alarm_out);
        chk("cpu reset on drop", 32'h1, cpu_reset);
        chk("irq on drop", 32'h0, irq_n);
        vdd_low <= 1'b0;
        while (alarm_out)
            @(posedge aclk);
        axr(CSS_STAT_OFS, 32'h10, 32'h10, 2'b00);
        // reset pin held for the full 100 us
        reset_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("cpu reset on pin", 32'h1, cpu_reset);
        repeat (20000) @(posedge aclk);
        reset_pin <= 1'b0;
        @(posedge aclk);
        while (alarm_out)
            @(posedge aclk);
        chk("notes left", 32'h0, bq.size() + pq.size());
        test_done();
    end
endmodule
